// ==== src/spci_dev.sv ====
// spci_dev: memory end, pin registers, command decoder, burst engine
// assumes the controller keeps the command timing; storage is a small window
`timescale 1ns/1ns
module spci_dev (
	input wire logic CLK,
	input wire logic RSTN,
	spci_if.dev BUS,
	output spci_pkg::spci_pwr_t PWR_STATE,
	output logic [spci_pkg::ROW_W-1:0] MODE_WORD,
	output logic BURST_BUSY
);
	import spci_pkg::*;

	logic cke_r, cs_n_r, ras_n_r, cas_n_r, we_n_r;
	logic [BANK_W-1:0] ba_r;
	logic [ROW_W-1:0] a_r;
	logic [1:0] mask_r;
	logic [DQ_W-1:0] dq_in_r;
	logic cke_s1_r, cke_s2_r, cke_s3_r;
	spci_pwr_t pwr_r;
	logic seen_low_r;
	logic [ROW_W-1:0] mode_r;
	logic [3:0] open_r;
	logic [3:0][ROW_W-1:0] row_r;
	logic burst_r, bwr_r, bap_r, bpage_r;
	logic [BANK_W-1:0] bbank_r;
	logic [COL_W-1:0] bcol_r, bleft_r;
	logic p1_v_r, p2_v_r;
	logic [DQ_W-1:0] p1_d_r, p2_d_r;
	logic [1:0] mask_d1_r;

	logic wake, live, sel;
	logic [3:0] cmd;
	logic is_rw, beat, last, cur_wr, cur_ap, cl3, out_v;
	logic [BANK_W-1:0] cur_bank;
	logic [COL_W-1:0] cur_col, len_m1, wrap, next_col;
	logic [STORE_AW-1:0] idx;
	logic [DQ_W-1:0] rd_word;

	function automatic logic [COL_W-1:0] len_of(input logic [2:0] code);
		case (code)
			BURST_LEN_1: len_of = 9'h000;
			BURST_LEN_2: len_of = 9'h001;
			BURST_LEN_4: len_of = 9'h003;
			BURST_LEN_8: len_of = 9'h007;
			default: len_of = 9'h1FF;
		endcase
	endfunction : len_of

	// the asynchronous wake path is filtered so a glitch cannot wake us
	assign wake = (pwr_r != PWR_RUN) && seen_low_r && cke_s2_r && cke_s3_r;
	assign live = (pwr_r == PWR_RUN) && cke_r;
	assign sel = live && !cs_n_r;
	assign cmd = {cs_n_r, ras_n_r, cas_n_r, we_n_r};
	assign len_m1 = len_of(mode_r[BURST_LENGTH_POS +: 3]);
	assign is_rw = sel && ((cmd == CMD_RD) || (cmd == CMD_WR)) && open_r[ba_r];
	// a burst keeps going while deselected, only commands are masked
	assign beat = is_rw || (live && burst_r);
	assign cur_bank = is_rw ? ba_r : bbank_r;
	assign cur_col = is_rw ? a_r[COL_W-1:0] : bcol_r;
	assign cur_wr = is_rw ? (cmd == CMD_WR) : bwr_r;
	assign cur_ap = is_rw ? a_r[AUTO_PRECHARGE_FLAG_POS] : bap_r;
	assign last = is_rw ? (len_m1 == 9'h000) : ((bleft_r == 9'h001) && !bpage_r);
	// sequential order wraps inside the burst block
	assign wrap = is_rw ? len_m1 : (bpage_r ? 9'h1FF : len_m1);
	assign next_col = (cur_col & ~wrap) | ((cur_col + 9'h001) & wrap);
	// storage window: low row and column bits alias onto a small array
	assign idx = {cur_bank, row_r[cur_bank][1:0], cur_col[3:0]};

	// pin registers; frozen while powered down, as if buffers were off
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			cke_r <= 1'b1;
			cs_n_r <= 1'b1;
			ras_n_r <= 1'b1;
			cas_n_r <= 1'b1;
			we_n_r <= 1'b1;
			ba_r <= '0;
			a_r <= '0;
			mask_r <= 2'h0;
			dq_in_r <= '0;
		end else if (pwr_r == PWR_RUN || wake) begin
			cke_r <= BUS.cke;
			cs_n_r <= BUS.cs_n;
			ras_n_r <= BUS.ras_n;
			cas_n_r <= BUS.cas_n;
			we_n_r <= BUS.we_n;
			ba_r <= BUS.ba;
			a_r <= BUS.addr;
			mask_r <= {BUS.data_mask_high_byte, BUS.data_mask_low_byte};
			dq_in_r <= BUS.dq;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			cke_s1_r <= 1'b1;
			cke_s2_r <= 1'b1;
			cke_s3_r <= 1'b1;
		end else begin
			cke_s1_r <= BUS.cke;
			cke_s2_r <= cke_s1_r;
			cke_s3_r <= cke_s2_r;
		end
	end

	// stalling during a burst is suspend; otherwise a low-power state
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			pwr_r <= PWR_RUN;
			seen_low_r <= 1'b0;
		end else begin
			case (pwr_r)
				PWR_RUN: begin
					seen_low_r <= 1'b0;
					if (!cke_r && !burst_r) begin
						if (!cs_n_r && cmd == CMD_REF)
							pwr_r <= PWR_SELF;
						else
							pwr_r <= PWR_DOWN;
					end
				end
				PWR_DOWN, PWR_SELF: begin
					if (!cke_s2_r && !cke_s3_r)
						seen_low_r <= 1'b1;
					if (wake)
						pwr_r <= PWR_RUN;
				end
				default: pwr_r <= PWR_RUN;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN)
			mode_r <= MODE_RESET;
		else if (sel && cmd == CMD_LMR)
			mode_r <= a_r;
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			open_r <= 4'h0;
			row_r <= '0;
		end else if (live) begin
			if (sel) begin
				case (cmd)
					CMD_ACT: begin
						open_r[ba_r] <= 1'b1;
						row_r[ba_r] <= a_r;
					end
					CMD_PRE: begin
						if (a_r[AUTO_PRECHARGE_FLAG_POS])
							open_r <= 4'h0;
						else
							open_r[ba_r] <= 1'b0;
					end
					default: ;
				endcase
			end
			if (beat && last && cur_ap)
				open_r[cur_bank] <= 1'b0;
		end
	end

	// a new read or write, a terminate, or a precharge of the burst bank or of all banks cuts the burst short
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			burst_r <= 1'b0;
			bwr_r <= 1'b0;
			bap_r <= 1'b0;
			bpage_r <= 1'b0;
			bbank_r <= '0;
			bcol_r <= '0;
			bleft_r <= '0;
		end else if (live) begin
			if (is_rw) begin
				burst_r <= !last;
				bwr_r <= (cmd == CMD_WR);
				bap_r <= a_r[AUTO_PRECHARGE_FLAG_POS];
				bpage_r <= (mode_r[BURST_LENGTH_POS +: 3] == BURST_LEN_PAGE);
				bbank_r <= ba_r;
				bcol_r <= next_col;
				bleft_r <= len_m1;
			end else if (sel && (cmd == CMD_BST ||
				(cmd == CMD_PRE && (a_r[AUTO_PRECHARGE_FLAG_POS] ||
				ba_r == bbank_r)))) begin
				burst_r <= 1'b0;
			end else if (burst_r) begin
				bcol_r <= next_col;
				bleft_r <= bleft_r - 9'h001;
				if (last)
					burst_r <= 1'b0;
			end
		end
	end

	generate
		for (genvar b = 0; b < 2; b++) begin : g_byte
			logic [7:0] mem [0:(1 << STORE_AW) - 1];
			always_ff @(posedge CLK) begin
				if (beat && cur_wr && !mask_r[b])
					mem[idx] <= dq_in_r[b*8 +: 8];
			end
			assign rd_word[b*8 +: 8] = mem[idx];
		end
	endgenerate

	// read pipeline and mask delay hold still during clock suspend
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			p1_v_r <= 1'b0;
			p2_v_r <= 1'b0;
			p1_d_r <= '0;
			p2_d_r <= '0;
			mask_d1_r <= 2'h0;
		end else if (live) begin
			p1_v_r <= beat && !cur_wr;
			p1_d_r <= rd_word;
			p2_v_r <= p1_v_r;
			p2_d_r <= p1_d_r;
			mask_d1_r <= mask_r;
		end
	end

	assign cl3 = (mode_r[CAS_LAT_POS +: 3] == CAS_LAT_3);
	assign out_v = (pwr_r == PWR_RUN) && (cl3 ? p2_v_r : p1_v_r);
	assign BUS.dev_dq_o = cl3 ? p2_d_r : p1_d_r;
	assign BUS.dev_dq_oe_n[0] = !(out_v && !mask_d1_r[0]);
	assign BUS.dev_dq_oe_n[1] = !(out_v && !mask_d1_r[1]);
	assign PWR_STATE = pwr_r;
	assign MODE_WORD = mode_r;
	assign BURST_BUSY = burst_r;
endmodule : spci_dev

// ==== src/spci_pkg.sv ====
// spci_pkg: constants, command codes and states shared by both link ends
// assumes one 100 MHz clock that both ends share
package spci_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int COL_W = 9;
	localparam int DQ_W = 16;
	localparam int STORE_AW = 8;
	localparam int AUTO_PRECHARGE_FLAG_POS = 10;
	localparam int BURST_LENGTH_POS = 0;
	localparam int CAS_LAT_POS = 4;
	localparam logic [2:0] BURST_LEN_1 = 3'h0;
	localparam logic [2:0] BURST_LEN_2 = 3'h1;
	localparam logic [2:0] BURST_LEN_4 = 3'h2;
	localparam logic [2:0] BURST_LEN_8 = 3'h3;
	localparam logic [2:0] BURST_LEN_PAGE = 3'h7;
	localparam logic [2:0] CAS_LAT_3 = 3'h3;
	// burst of one, read latency two
	localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;
	localparam int HOST_CL = 2;
	localparam int RD_MASK_LAT = 2;
	localparam int T_RCD_NS = 20;
	localparam int T_RP_NS = 20;
	localparam int T_WR_NS = 15;
	localparam int T_RFC_NS = 70;
	localparam int T_XSR_NS = 80;
	localparam int T_REFI_NS = 7800;
	localparam int T_INIT_NS = 100000;
	localparam int T_MRD_CYC = 2;
	localparam int T_RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
	localparam int T_XSR_CYC = (T_XSR_NS * CLK_MHZ + 999) / 1000;
	localparam int T_REFI_CYC = T_REFI_NS * CLK_MHZ / 1000;
	localparam int T_INIT_CYC = (T_INIT_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [3:0] {
		CMD_LMR = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR = 4'h4,
		CMD_RD = 4'h5,
		CMD_BST = 4'h6,
		CMD_NOP = 4'h7
	} spci_cmd_t;
	typedef enum logic [1:0] {
		PWR_RUN = 2'h0,
		PWR_DOWN = 2'h1,
		PWR_SELF = 2'h3
	} spci_pwr_t;
endpackage : spci_pkg

// ==== src/spci_if.sv ====
// spci_if: pin bundle between controller end and memory end
// assumes both ends run on the same clock; data bus resolved per byte here
`timescale 1ns/1ns
interface spci_if;
	import spci_pkg::*;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [BANK_W-1:0] ba;
	logic [ROW_W-1:0] addr;
	logic data_mask_low_byte;
	logic data_mask_high_byte;
	logic [DQ_W-1:0] host_dq_o;
	logic [1:0] host_dq_oe_n;
	logic [DQ_W-1:0] dev_dq_o;
	logic [1:0] dev_dq_oe_n;
	logic [DQ_W-1:0] dq;
	// an undriven byte reads as zero; no keeper is modelled
	always_comb begin
		dq = 16'h0000;
		for (int b = 0; b < 2; b++) begin
			if (!host_dq_oe_n[b])
				dq[b*8 +: 8] = host_dq_o[b*8 +: 8];
			else if (!dev_dq_oe_n[b])
				dq[b*8 +: 8] = dev_dq_o[b*8 +: 8];
		end
	end
	modport host (output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		data_mask_low_byte, data_mask_high_byte, host_dq_o, host_dq_oe_n,
		input dq);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
		data_mask_low_byte, data_mask_high_byte, dq,
		output dev_dq_o, dev_dq_oe_n);
endinterface : spci_if

// ==== src/spci_host.sv ====
// spci_host: controller end, init, single-word access, refresh, sleep
// assumes the memory end shares CLK; every access uses auto precharge
`timescale 1ns/1ns
module spci_host #(
	parameter int INIT_CYC = spci_pkg::T_INIT_CYC
) (
	input wire logic CLK,
	input wire logic RSTN,
	spci_if.host BUS,
	input wire logic REQ,
	input wire logic WRITE,
	input wire logic [spci_pkg::BANK_W-1:0] BANK,
	input wire logic [spci_pkg::ROW_W-1:0] ROW,
	input wire logic [spci_pkg::COL_W-1:0] COL,
	input wire logic [spci_pkg::DQ_W-1:0] WDATA,
	input wire logic [1:0] WMASK,
	input wire logic SLEEP,
	output logic READY,
	output logic RVALID,
	output logic [spci_pkg::DQ_W-1:0] RDATA,
	output logic ASLEEP
);
	import spci_pkg::*;

	typedef enum logic [3:0] {
		H_INIT = 4'h0,
		H_IPRE = 4'h1,
		H_ILMR = 4'h3,
		H_IDLE = 4'h2,
		H_ACTV = 4'h6,
		H_WAIT = 4'h7,
		H_SLEEP = 4'h5
	} spci_hst_t;

	spci_hst_t st_r;
	spci_cmd_t cmd_r;
	logic [13:0] cnt_r;
	logic cke_r, oe_n_r, req_we_r, ref_due_r, rvalid_r;
	logic [BANK_W-1:0] ba_r;
	logic [ROW_W-1:0] a_r;
	logic [1:0] mask_r, req_mask_r;
	logic [COL_W-1:0] req_col_r;
	logic [DQ_W-1:0] dq_o_r, req_data_r, rdata_r;
	logic [9:0] refi_r;
	logic [HOST_CL:0] rd_sh_r;
	logic ref_go, rd_go;

	// refresh and sleep take priority over a new access
	assign ref_go = (st_r == H_IDLE) && (ref_due_r || SLEEP);
	assign rd_go = (st_r == H_ACTV) && (cnt_r == 14'h0000) && !req_we_r;
	assign READY = (st_r == H_IDLE) && !ref_due_r && !SLEEP;

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st_r <= H_INIT;
			cnt_r <= 14'(INIT_CYC);
			cmd_r <= CMD_NOP;
			cke_r <= 1'b1;
			oe_n_r <= 1'b1;
			ba_r <= '0;
			a_r <= '0;
			mask_r <= 2'h0;
			dq_o_r <= '0;
			req_we_r <= 1'b0;
			req_col_r <= '0;
			req_data_r <= '0;
			req_mask_r <= 2'h0;
		end else begin
			cmd_r <= CMD_NOP;
			oe_n_r <= 1'b1;
			mask_r <= 2'h0;
			if (cnt_r != 14'h0000)
				cnt_r <= cnt_r - 14'h0001;
			case (st_r)
				H_INIT: if (cnt_r == 14'h0000) begin
					cmd_r <= CMD_PRE;
					a_r <= 12'h400;
					cnt_r <= 14'(T_RP_CYC - 1);
					st_r <= H_IPRE;
				end
				H_IPRE: if (cnt_r == 14'h0000) begin
					cmd_r <= CMD_LMR;
					a_r <= MODE_RESET;
					ba_r <= '0;
					cnt_r <= 14'(T_MRD_CYC - 1);
					st_r <= H_ILMR;
				end
				H_ILMR: if (cnt_r == 14'h0000)
					st_r <= H_IDLE;
				H_IDLE: begin
					if (ref_go) begin
						cmd_r <= CMD_REF;
						// refresh with clock enable low enters self refresh
						cke_r <= !SLEEP;
						cnt_r <= 14'(T_RFC_CYC - 1);
						st_r <= SLEEP ? H_SLEEP : H_WAIT;
					end else if (REQ) begin
						cmd_r <= CMD_ACT;
						ba_r <= BANK;
						a_r <= ROW;
						req_we_r <= WRITE;
						req_col_r <= COL;
						req_data_r <= WDATA;
						req_mask_r <= WMASK;
						cnt_r <= 14'(T_RCD_CYC - 1);
						st_r <= H_ACTV;
					end
				end
				H_ACTV: if (cnt_r == 14'h0000) begin
					cmd_r <= req_we_r ? CMD_WR : CMD_RD;
					a_r <= {3'h2, req_col_r};
					// the mask also floats the bytes of a read
					mask_r <= req_mask_r;
					if (req_we_r) begin
						dq_o_r <= req_data_r;
						oe_n_r <= 1'b0;
						cnt_r <= 14'(T_WR_CYC + T_RP_CYC);
					end else begin
						cnt_r <= 14'(HOST_CL + T_RP_CYC);
					end
					st_r <= H_WAIT;
				end
				H_WAIT: if (cnt_r == 14'h0000)
					st_r <= H_IDLE;
				H_SLEEP: if (!SLEEP) begin
					cke_r <= 1'b1;
					cnt_r <= 14'(T_XSR_CYC);
					st_r <= H_WAIT;
				end
				default: st_r <= H_INIT;
			endcase
		end
	end

	// due flag: a new interval end wins over the clear in the same cycle
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			refi_r <= 10'(T_REFI_CYC - 1);
			ref_due_r <= 1'b0;
		end else begin
			if (ref_go)
				ref_due_r <= 1'b0;
			if (refi_r == 10'h000) begin
				refi_r <= 10'(T_REFI_CYC - 1);
				ref_due_r <= 1'b1;
			end else begin
				refi_r <= refi_r - 10'h001;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			rd_sh_r <= '0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
		end else begin
			rd_sh_r <= {rd_sh_r[HOST_CL-1:0], rd_go};
			rvalid_r <= rd_sh_r[HOST_CL];
			if (rd_sh_r[HOST_CL])
				rdata_r <= BUS.dq;
		end
	end

	assign BUS.cke = cke_r;
	assign BUS.cs_n = cmd_r[3];
	assign BUS.ras_n = cmd_r[2];
	assign BUS.cas_n = cmd_r[1];
	assign BUS.we_n = cmd_r[0];
	assign BUS.ba = ba_r;
	assign BUS.addr = a_r;
	assign BUS.data_mask_low_byte = mask_r[0];
	assign BUS.data_mask_high_byte = mask_r[1];
	assign BUS.host_dq_o = dq_o_r;
	assign BUS.host_dq_oe_n = {oe_n_r, oe_n_r};
	assign RVALID = rvalid_r;
	assign RDATA = rdata_r;
	assign ASLEEP = (st_r == H_SLEEP);
endmodule : spci_host

// ==== verif/spci_props.sv ====
// spci_props: timing checks on the pins joining controller and memory
// assumes burst of one, read latency two and one clock for both ends
`timescale 1ns/1ns
module spci_props (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [spci_pkg::BANK_W-1:0] ba,
	input wire logic [spci_pkg::ROW_W-1:0] addr,
	input wire logic data_mask_low_byte,
	input wire logic data_mask_high_byte,
	input wire logic [1:0] host_dq_oe_n,
	input wire logic [1:0] dev_dq_oe_n
);
	import spci_pkg::*;
	logic [3:0] cmd;
	logic rd_c;
	logic col_c;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign rd_c = cke && cmd == CMD_RD;
	assign col_c = rd_c || (cke && cmd == CMD_WR);
	default clocking dcb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	property p_rd_drive;
		rd_c && !data_mask_low_byte |-> ##2 !dev_dq_oe_n[0];
	endproperty
	a_rd_drive: assert property (p_rd_drive)
		else $error("read data not driven");
	property p_drive_cause;
		!dev_dq_oe_n[0] |-> $past(rd_c, 2);
	endproperty
	a_drive_cause: assert property (p_drive_cause)
		else $error("data driven without read");
	property p_mask_lo;
		data_mask_low_byte |-> ##2 dev_dq_oe_n[0];
	endproperty
	a_mask_lo: assert property (p_mask_lo)
		else $error("low byte not floated");
	property p_mask_hi;
		data_mask_high_byte |-> ##2 dev_dq_oe_n[1];
	endproperty
	a_mask_hi: assert property (p_mask_hi)
		else $error("high byte not floated");
	property p_host_drive;
		$fell(host_dq_oe_n[0]) |-> cke && cmd == CMD_WR;
	endproperty
	a_host_drive: assert property (p_host_drive)
		else $error("write data off its command");
	property p_act_first;
		col_c |-> $past(cmd, 2) == CMD_ACT && $past(ba, 2) == ba;
	endproperty
	a_act_first: assert property (p_act_first)
		else $error("column access without open row");
	property p_auto_pre;
		col_c |-> addr[AUTO_PRECHARGE_FLAG_POS];
	endproperty
	a_auto_pre: assert property (p_auto_pre)
		else $error("access without auto precharge");
	property p_pre_all;
		cke && cmd == CMD_PRE |-> addr[AUTO_PRECHARGE_FLAG_POS];
	endproperty
	a_pre_all: assert property (p_pre_all)
		else $error("precharge not to all banks");
	property p_mode;
		cke && cmd == CMD_LMR |-> addr == MODE_RESET;
	endproperty
	a_mode: assert property (p_mode)
		else $error("wrong mode word");
	property p_sleep_in;
		$fell(cke) |-> cmd == CMD_REF;
	endproperty
	a_sleep_in: assert property (p_sleep_in)
		else $error("clock enable dropped without refresh");
	property p_quiet;
		!cke |-> dev_dq_oe_n == 2'h3;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("memory drives while asleep");
endmodule : spci_props

// ==== verif/tb_top.sv ====
// tb_top: both link ends joined, random traffic checked against a model
// assumes a short init count and a 100 MHz clock
`timescale 1ns/1ns
`define CHK(x, e) begin checked++; if ((x) !== (e)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, x, e); end end
module tb_top;
	import spci_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req = 1'b0;
	logic wr = 1'b0;
	logic sleep = 1'b0;
	logic [1:0] bank = 2'h0;
	logic [1:0] wmask = 2'h0;
	logic [11:0] row = 12'h000;
	logic [8:0] col = 9'h000;
	logic [15:0] wdata = 16'h0000;
	logic ready, rvalid, asleep, busy;
	logic [15:0] rdata;
	logic [11:0] mode;
	spci_pwr_t pwr;
	logic [2:0] st;
	int n_fail = 0;
	int checked = 0;
	logic [15:0] mem [int];
	logic [22:0] adr [$];
	logic [22:0] a;
	assign st = {asleep, rvalid, ready};
	always #5 clk = ~clk;
	spci_if bus ();
	spci_host #(.INIT_CYC(20)) spci_host_inst (
		.CLK(clk), .RSTN(rst_n), .BUS(bus.host), .REQ(req), .WRITE(wr),
		.BANK(bank), .ROW(row), .COL(col), .WDATA(wdata), .WMASK(wmask),
		.SLEEP(sleep), .READY(ready), .RVALID(rvalid), .RDATA(rdata),
		.ASLEEP(asleep));
	spci_dev spci_dev_inst (.CLK(clk), .RSTN(rst_n), .BUS(bus.dev),
		.PWR_STATE(pwr), .MODE_WORD(mode), .BURST_BUSY(busy));
	spci_props spci_props_inst (.CLK(clk), .RSTN(rst_n), .cke(bus.cke),
		.cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
		.we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr),
		.data_mask_low_byte(bus.data_mask_low_byte),
		.data_mask_high_byte(bus.data_mask_high_byte),
		.host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));
	task automatic tally_and_finish();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// sampled on the falling edge so the value has settled
	task automatic wait_hi(input int k);
		int i;
		i = 0;
		@(negedge clk);
		while (st[k] !== 1'b1 && i < 3000) begin
			@(negedge clk);
			i++;
		end
		if (i == 3000) begin
			n_fail++;
			$display("[FAIL] %0t no handshake", $time);
		end
	endtask : wait_hi
	// request held until an edge that sees ready, so refresh cannot eat it
	task automatic issue(input logic w, input logic [22:0] x,
		input logic [15:0] d, input logic [1:0] m);
		@(posedge clk);
		req <= 1'b1;
		wr <= w;
		{bank, row, col} <= x;
		wdata <= d;
		wmask <= m;
		wait_hi(0);
		@(posedge clk);
		req <= 1'b0;
	endtask : issue
	// storage window aliases on bank, two row bits and four column bits
	function automatic int key(input logic [22:0] x);
		return int'({x[22:21], x[10:9], x[3:0]});
	endfunction : key
	task automatic wr_op(input logic [22:0] x, input logic [15:0] d,
		input logic [1:0] m);
		logic [15:0] v;
		v = mem.exists(key(x)) ? mem[key(x)] : d;
		if (!m[0])
			v[7:0] = d[7:0];
		if (!m[1])
			v[15:8] = d[15:8];
		mem[key(x)] = v;
		issue(1'b1, x, d, m);
	endtask : wr_op
	// a masked read byte is left undriven and reads as zero
	task automatic rd_op(input logic [22:0] x, input logic [1:0] m);
		logic [15:0] v;
		v = mem[key(x)];
		if (m[0])
			v[7:0] = 8'h00;
		if (m[1])
			v[15:8] = 8'h00;
		issue(1'b0, x, 16'h0000, m);
		wait_hi(1);
		`CHK(rdata, v)
		`CHK(busy, 1'b0)
	endtask : rd_op
	initial begin
		void'($urandom(88));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wait_hi(0);
		`CHK(mode, MODE_RESET)
		`CHK(pwr, PWR_RUN)
		repeat (24) begin
			a = 23'($urandom);
			adr.push_back(a);
			wr_op(a, 16'($urandom), 2'h0);
		end
		foreach (adr[i])
			rd_op(adr[i], 2'h0);
		for (int m = 0; m < 4; m++) begin
			a = 23'($urandom);
			wr_op(a, 16'($urandom), 2'h0);
			wr_op(a, 16'($urandom), 2'(m));
			rd_op(a, 2'h0);
			rd_op(a, 2'(m));
		end
		@(posedge clk);
		sleep <= 1'b1;
		wait_hi(2);
		repeat (40) @(negedge clk);
		`CHK(pwr, PWR_SELF)
		`CHK(asleep, 1'b1)
		@(posedge clk);
		sleep <= 1'b0;
		wait_hi(0);
		`CHK(pwr, PWR_RUN)
		foreach (adr[i])
			rd_op(adr[i], 2'($urandom));
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t watchdog", $time);
		tally_and_finish();
	end
endmodule : tb_top
